/* inc/mhd_pkg.sv */
// Shared constants and types of the message object handler.
`default_nettype none
package mhd_pkg;
  localparam int MHD_NUM_OBJ = 32;
  localparam int MHD_IDX_W = 5;
  localparam int MHD_NUM_W = 6;
  localparam int MHD_NUM_SETS = 2;
  localparam int MHD_SET_W = 1;
  localparam int MHD_ID_W = 29;
  localparam int MHD_STD_LOW = 18;
  localparam int MHD_DATA_W = 64;
  localparam int MHD_HALF_W = 32;
  localparam int MHD_DLC_W = 4;
  localparam int MHD_CM_W = 8;
  localparam int MHD_CM_WR = 7;
  localparam int MHD_CM_MASK = 6;
  localparam int MHD_CM_ARB = 5;
  localparam int MHD_CM_CTRL = 4;
  localparam int MHD_CM_CLRINT = 3;
  localparam int MHD_CM_TXRQ = 2;
  localparam int MHD_CM_DATAA = 1;
  localparam int MHD_CM_DATAB = 0;
  localparam logic [MHD_NUM_W-1:0] MHD_MAX_NUM = 6'h20;

  typedef struct packed {
    logic object_valid;
    logic new_data_flag;
    logic object_irq_pending;
    logic transmit_request;
  } mhd_flags_t;

  typedef struct packed {
    logic [MHD_ID_W-1:0] identifier_mask;
    logic mask_extended_flag;
    logic mask_direction_flag;
    logic use_acceptance_mask;
    logic [MHD_ID_W-1:0] object_identifier;
    logic xtd;
    logic dir;
    logic message_lost;
    logic rx_irq_enable;
    logic tx_irq_enable;
    logic remote_answer_enable;
    logic end_of_block;
    logic fd_format;
    logic bit_rate_switch;
    logic error_state;
    logic [MHD_DLC_W-1:0] dlc;
    logic [MHD_DATA_W-1:0] data;
  } mhd_cfg_t;

  typedef struct packed {
    mhd_flags_t flags;
    mhd_cfg_t cfg;
  } mhd_obj_t;

  typedef struct packed {
    logic [MHD_ID_W-1:0] id;
    logic xtd;
    logic remote;
    logic fd_format;
    logic bit_rate_switch;
    logic error_state;
    logic [MHD_DLC_W-1:0] dlc;
  } mhd_hdr_t;

  // Replaces the groups of base that the command mask selects by those of src.
  function automatic mhd_obj_t mhd_merge(mhd_obj_t base, mhd_obj_t src,
                                         logic [MHD_CM_W-1:0] cm);
    mhd_obj_t r;
    r = base;
    if (cm[MHD_CM_MASK]) begin
      r.cfg.identifier_mask = src.cfg.identifier_mask;
      r.cfg.mask_extended_flag = src.cfg.mask_extended_flag;
      r.cfg.mask_direction_flag = src.cfg.mask_direction_flag;
      r.cfg.use_acceptance_mask = src.cfg.use_acceptance_mask;
    end
    if (cm[MHD_CM_ARB]) begin
      r.cfg.object_identifier = src.cfg.object_identifier;
      r.cfg.xtd = src.cfg.xtd;
      r.cfg.dir = src.cfg.dir;
      r.flags.object_valid = src.flags.object_valid;
    end
    if (cm[MHD_CM_CTRL]) begin
      r.flags.new_data_flag = src.flags.new_data_flag;
      r.flags.object_irq_pending = src.flags.object_irq_pending;
      r.flags.transmit_request = src.flags.transmit_request;
      r.cfg.message_lost = src.cfg.message_lost;
      r.cfg.rx_irq_enable = src.cfg.rx_irq_enable;
      r.cfg.tx_irq_enable = src.cfg.tx_irq_enable;
      r.cfg.remote_answer_enable = src.cfg.remote_answer_enable;
      r.cfg.end_of_block = src.cfg.end_of_block;
      r.cfg.fd_format = src.cfg.fd_format;
      r.cfg.bit_rate_switch = src.cfg.bit_rate_switch;
      r.cfg.error_state = src.cfg.error_state;
      r.cfg.dlc = src.cfg.dlc;
    end
    if (cm[MHD_CM_DATAA]) begin
      r.cfg.data[MHD_HALF_W-1:0] = src.cfg.data[MHD_HALF_W-1:0];
    end
    if (cm[MHD_CM_DATAB]) begin
      r.cfg.data[MHD_DATA_W-1:MHD_HALF_W] = src.cfg.data[MHD_DATA_W-1:MHD_HALF_W];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

/* inc/mhd_if.sv */
// Connection between the message handler and its host and protocol core.
`timescale 1ns/1ps
`default_nettype none
interface mhd_if;
  import mhd_pkg::*;
  logic [MHD_NUM_SETS-1:0] cmd_valid;
  logic [MHD_NUM_SETS-1:0][MHD_NUM_W-1:0] cmd_obj;
  logic [MHD_NUM_SETS-1:0][MHD_CM_W-1:0] cmd_mask;
  logic [MHD_NUM_SETS-1:0] buf_wr;
  mhd_obj_t [MHD_NUM_SETS-1:0] buf_wdata;
  mhd_obj_t [MHD_NUM_SETS-1:0] buf_rdata;
  logic [MHD_NUM_SETS-1:0] busy;
  logic core_ready;
  logic tx_load;
  mhd_hdr_t tx_hdr;
  logic [MHD_DATA_W-1:0] tx_data;
  logic tx_ok;
  logic tx_fail;
  logic rx_hdr_valid;
  mhd_hdr_t rx_hdr;
  logic rx_end_ok;
  logic [MHD_DATA_W-1:0] rx_data;

  modport device (
    input cmd_valid, cmd_obj, cmd_mask, buf_wr, buf_wdata,
    input core_ready, tx_ok, tx_fail, rx_hdr_valid, rx_hdr, rx_end_ok, rx_data,
    output busy, buf_rdata, tx_load, tx_hdr, tx_data
  );
  modport host (
    output cmd_valid, cmd_obj, cmd_mask, buf_wr, buf_wdata,
    output core_ready, tx_ok, tx_fail, rx_hdr_valid, rx_hdr, rx_end_ok, rx_data,
    input busy, buf_rdata, tx_load, tx_hdr, tx_data
  );
endinterface
`default_nettype wire

/* rtl/mhd_host.sv */
// Host end: sequences buffer transfers and registers the protocol core signals.
`timescale 1ns/1ps
`default_nettype none
module mhd_host (
  input wire logic clk,
  input wire logic reset_n,
  mhd_if.host bus,
  input wire logic req_valid,
  input wire logic [mhd_pkg::MHD_SET_W-1:0] req_set,
  input wire logic [mhd_pkg::MHD_NUM_W-1:0] req_obj,
  input wire logic [mhd_pkg::MHD_CM_W-1:0] req_cmask,
  input wire mhd_pkg::mhd_obj_t req_buf,
  input wire logic req_tx_init,
  output logic req_ready,
  output logic done,
  output mhd_pkg::mhd_obj_t result,
  input wire logic core_ready_in,
  input wire logic tx_ok_in,
  input wire logic tx_fail_in,
  input wire logic rx_hdr_valid_in,
  input wire mhd_pkg::mhd_hdr_t rx_hdr_in,
  input wire logic rx_end_ok_in,
  input wire logic [mhd_pkg::MHD_DATA_W-1:0] rx_data_in,
  output logic tx_load_out,
  output mhd_pkg::mhd_hdr_t tx_hdr_out,
  output logic [mhd_pkg::MHD_DATA_W-1:0] tx_data_out
);
  import mhd_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOAD = 2'b01,
    H_CMD = 2'b10,
    H_WAIT = 2'b11
  } mhd_hstate_t;

  mhd_hstate_t state_reg;
  logic [MHD_SET_W-1:0] set_reg;
  logic [MHD_NUM_W-1:0] obj_reg;
  logic [MHD_CM_W-1:0] cm_reg;
  logic [MHD_CM_W-1:0] cm_next;
  mhd_obj_t buf_reg;
  mhd_obj_t buf_next;
  logic buf_wr_reg;
  logic cmd_valid_reg;

  // Prepares a transmit object: valid, end of block, transmit direction, flags clear.
  function automatic mhd_obj_t mhd_tx_init(mhd_obj_t b);
    mhd_obj_t r;
    r = b;
    r.flags = '0;
    r.flags.object_valid = 1'b1;
    r.cfg.end_of_block = 1'b1;
    r.cfg.dir = 1'b1;
    r.cfg.message_lost = 1'b0;
    r.cfg.rx_irq_enable = 1'b0;
    if (!r.cfg.xtd) begin
      r.cfg.object_identifier[MHD_STD_LOW-1:0] = '0;
    end
    return r;
  endfunction

  // A new command is offered only while the chosen set is idle.
  assign req_ready = (state_reg == H_IDLE) && !bus.busy[req_set];

  always_comb begin
    buf_next = req_tx_init ? mhd_tx_init(req_buf) : req_buf;
    cm_next = req_cmask;
    // A transmit request is only raised together with both data halves.
    if (!(req_cmask[MHD_CM_DATAA] && req_cmask[MHD_CM_DATAB])) begin
      cm_next[MHD_CM_TXRQ] = req_cmask[MHD_CM_TXRQ] && !req_cmask[MHD_CM_WR];
    end
  end

  always_comb begin
    bus.buf_wr = '0;
    bus.cmd_valid = '0;
    bus.buf_wr[set_reg] = buf_wr_reg;
    bus.cmd_valid[set_reg] = cmd_valid_reg;
    for (int s = 0; s < MHD_NUM_SETS; s++) begin
      bus.buf_wdata[s] = buf_reg;
      bus.cmd_obj[s] = obj_reg;
      bus.cmd_mask[s] = cm_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= H_IDLE;
      set_reg <= '0;
      obj_reg <= '0;
      cm_reg <= '0;
      buf_reg <= '0;
      buf_wr_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        H_IDLE: begin
          if (req_valid && req_ready) begin
            set_reg <= req_set;
            obj_reg <= req_obj;
            cm_reg <= cm_next;
            buf_reg <= buf_next;
            buf_wr_reg <= 1'b1;
            state_reg <= H_LOAD;
          end
        end
        H_LOAD: begin
          buf_wr_reg <= 1'b0;
          cmd_valid_reg <= 1'b1;
          state_reg <= H_CMD;
        end
        H_CMD: begin
          cmd_valid_reg <= 1'b0;
          state_reg <= H_WAIT;
        end
        H_WAIT: begin
          if (!bus.busy[set_reg]) begin
            result <= bus.buf_rdata[set_reg];
            done <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Protocol core side, one register stage each way.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.core_ready <= 1'b0;
      bus.tx_ok <= 1'b0;
      bus.tx_fail <= 1'b0;
      bus.rx_hdr_valid <= 1'b0;
      bus.rx_hdr <= '0;
      bus.rx_end_ok <= 1'b0;
      bus.rx_data <= '0;
      tx_load_out <= 1'b0;
      tx_hdr_out <= '0;
      tx_data_out <= '0;
    end else begin
      bus.core_ready <= core_ready_in;
      bus.tx_ok <= tx_ok_in;
      bus.tx_fail <= tx_fail_in;
      bus.rx_hdr_valid <= rx_hdr_valid_in;
      bus.rx_hdr <= rx_hdr_in;
      bus.rx_end_ok <= rx_end_ok_in;
      bus.rx_data <= rx_data_in;
      tx_load_out <= bus.tx_load;
      tx_hdr_out <= bus.tx_hdr;
      tx_data_out <= bus.tx_data;
    end
  end
endmodule
`default_nettype wire

/* rtl/mhd_device.sv */
// Message handler: host buffer transfers, acceptance filtering and transmit selection.
// Operation
// - Reset clears only the four object flags.
// - Software initialises or invalidates every object.
// - Busy is high throughout a buffer transfer.
// - Writes run as read-modify-write of the object.
// - Partial write refreshes unselected buffer parts.
// - Partial read keeps unselected buffer parts.
// - Load best pending object, clear its new-data.
// - Success clears request if no new data; interrupt if transmit enabled.
// - Failed frames retry through fresh priority selection.
// - Scan objects upward from one, stop at match.
// - Data frame stores data, identifier and length.
// - Store sets new-data; lost if already set.
// - Store sets interrupt pending when receive enabled.
// - Stored data frame clears the transmit request.
// - Remote frame with answer enable sets request.
// - Unmasked remote without answer enable is ignored.
// - Masked remote without answer stores header only.
// - Remote frames always go out classical format.
// - Lower object number wins receive and transmit.
// - Transmit objects start valid, final, transmit direction.
// - Standard identifiers sit in the top bits.
// - Request only after length and data are valid; the host requires both data halves, not the length.
`timescale 1ns/1ps
`default_nettype none
module mhd_device (
  input wire logic clk,
  input wire logic reset_n,
  mhd_if.device bus,
  output logic [mhd_pkg::MHD_NUM_OBJ-1:0] valid_status,
  output logic [mhd_pkg::MHD_NUM_OBJ-1:0] new_data_flag_status,
  output logic [mhd_pkg::MHD_NUM_OBJ-1:0] object_irq_pending_status,
  output logic [mhd_pkg::MHD_NUM_OBJ-1:0] transmit_request_status
);
  import mhd_pkg::*;

  if (MHD_NUM_OBJ > (1 << MHD_IDX_W) || MHD_NUM_SETS > (1 << MHD_SET_W)) begin : g_bad
    $error("Object or set count does not fit its index width.");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_RMW = 3'b010,
    ST_WRITE = 3'b011,
    ST_SCAN = 3'b100
  } mhd_state_t;

  // ****************************************
  // State
  // ****************************************
  mhd_cfg_t cfg_mem [MHD_NUM_OBJ];
  logic [MHD_NUM_OBJ-1:0] valid_reg, new_data_flag_reg, object_irq_pending_reg, transmit_request_reg;
  logic [MHD_NUM_OBJ-1:0] valid_next, new_data_flag_next, object_irq_pending_next, transmit_request_next;
  mhd_state_t state_reg;
  logic [MHD_SET_W-1:0] set_reg;
  logic [MHD_NUM_SETS-1:0] busy_reg;
  logic [MHD_NUM_SETS-1:0][MHD_NUM_W-1:0] cmd_obj_reg;
  logic [MHD_NUM_SETS-1:0][MHD_CM_W-1:0] cmd_mask_reg;
  mhd_obj_t [MHD_NUM_SETS-1:0] buf_reg;
  logic [MHD_IDX_W-1:0] scan_idx_reg, match_idx_reg, tx_idx_reg;
  logic rx_pend_reg, store_pend_reg, match_valid_reg;
  logic tx_busy_reg, tx_nd_seen_reg, tx_load_reg;
  mhd_hdr_t hdr_reg, tx_hdr_reg, tx_hdr_next;
  logic [MHD_DATA_W-1:0] rx_data_reg, tx_data_reg;
  logic [MHD_NUM_W-1:0] num_m1;
  logic [MHD_IDX_W-1:0] obj_idx, tx_sel, mem_idx;
  logic [MHD_CM_W-1:0] cm;
  logic [MHD_SET_W-1:0] pick_set;
  logic host_pend, pick_ok, do_store, do_tx_load, tx_any, mem_we, busy_clr;
  mhd_obj_t cur_obj, wbuf;
  mhd_cfg_t mem_wdata, rcfg, tcfg;

  // Acceptance test of one object against a received header.
  function automatic logic mhd_match(mhd_cfg_t c, logic valid, logic nd, mhd_hdr_t h);
    logic [MHD_ID_W-1:0] m;
    logic xm;
    logic dm;
    m = c.use_acceptance_mask ? c.identifier_mask : '1;
    if (!h.xtd) begin
      m[MHD_STD_LOW-1:0] = '0;
    end
    xm = c.use_acceptance_mask ? c.mask_extended_flag : 1'b1;
    dm = c.use_acceptance_mask ? c.mask_direction_flag : 1'b1;
    // A filled object inside a receive block is locked until software frees it.
    return valid && (((c.object_identifier ^ h.id) & m) == '0) && (!xm || c.xtd == h.xtd)
           && (!dm || c.dir == h.remote) && !(!h.remote && nd && !c.end_of_block);
  endfunction

  // ****************************************
  // Selection
  // ****************************************
  assign host_pend = |busy_reg;
  assign cm = cmd_mask_reg[set_reg];
  assign num_m1 = cmd_obj_reg[set_reg] - 6'h01;
  assign obj_idx = num_m1[MHD_IDX_W-1:0];
  assign cur_obj = '{flags: '{valid_reg[obj_idx], new_data_flag_reg[obj_idx], object_irq_pending_reg[obj_idx],
                              transmit_request_reg[obj_idx]}, cfg: cfg_mem[obj_idx]};
  assign do_store = (state_reg == ST_IDLE) && !host_pend && store_pend_reg && !rx_pend_reg;
  assign do_tx_load = (state_reg == ST_IDLE) && !host_pend && !do_store && bus.core_ready
                      && !tx_busy_reg && !tx_load_reg && tx_any;
  assign busy_clr = (state_reg == ST_READ) || (state_reg == ST_WRITE)
                    || ((state_reg == ST_IDLE) && host_pend && !pick_ok);

  always_comb begin
    pick_set = '0;
    for (int s = MHD_NUM_SETS - 1; s >= 0; s--) begin
      if (busy_reg[s]) begin
        pick_set = MHD_SET_W'(s);
      end
    end
    pick_ok = (cmd_obj_reg[pick_set] != '0) && (cmd_obj_reg[pick_set] <= MHD_MAX_NUM);
  end

  always_comb begin
    tx_any = 1'b0;
    tx_sel = '0;
    for (int i = MHD_NUM_OBJ - 1; i >= 0; i--) begin
      if (valid_reg[i] && transmit_request_reg[i]) begin
        tx_any = 1'b1;
        tx_sel = MHD_IDX_W'(i);
      end
    end
    tcfg = cfg_mem[tx_sel];
    tx_hdr_next = '{id: tcfg.object_identifier, xtd: tcfg.xtd, remote: !tcfg.dir,
                    fd_format: tcfg.dir && tcfg.fd_format,
                    bit_rate_switch: tcfg.dir && tcfg.bit_rate_switch,
                    error_state: tcfg.dir && tcfg.error_state, dlc: tcfg.dlc};
  end

  // ****************************************
  // Object updates
  // ****************************************
  always_comb begin
    valid_next = valid_reg;
    new_data_flag_next = new_data_flag_reg;
    object_irq_pending_next = object_irq_pending_reg;
    transmit_request_next = transmit_request_reg;
    mem_we = 1'b0;
    mem_idx = obj_idx;
    wbuf = buf_reg[set_reg];
    mem_wdata = wbuf.cfg;
    rcfg = cfg_mem[match_idx_reg];
    if (bus.tx_ok && tx_busy_reg && !tx_nd_seen_reg && !new_data_flag_reg[tx_idx_reg]) begin
      transmit_request_next[tx_idx_reg] = 1'b0;
    end
    if (state_reg == ST_READ) begin
      if (cm[MHD_CM_CLRINT]) begin
        object_irq_pending_next[obj_idx] = 1'b0;
      end
      if (cm[MHD_CM_TXRQ]) begin
        new_data_flag_next[obj_idx] = 1'b0;
      end
    end
    if (state_reg == ST_WRITE) begin
      mem_we = 1'b1;
      valid_next[obj_idx] = wbuf.flags.object_valid;
      new_data_flag_next[obj_idx] = wbuf.flags.new_data_flag;
      object_irq_pending_next[obj_idx] = wbuf.flags.object_irq_pending && !cm[MHD_CM_CLRINT];
      transmit_request_next[obj_idx] = wbuf.flags.transmit_request || cm[MHD_CM_TXRQ];
    end
    if (do_store && match_valid_reg) begin
      mem_idx = match_idx_reg;
      if (!hdr_reg.remote) begin
        rcfg.object_identifier = hdr_reg.id;
        rcfg.xtd = hdr_reg.xtd;
        rcfg.dlc = hdr_reg.dlc;
        rcfg.data = rx_data_reg;
        rcfg.fd_format = hdr_reg.fd_format;
        rcfg.bit_rate_switch = hdr_reg.bit_rate_switch;
        rcfg.error_state = hdr_reg.error_state;
        rcfg.message_lost = rcfg.message_lost || new_data_flag_reg[match_idx_reg];
        mem_we = 1'b1;
        new_data_flag_next[match_idx_reg] = 1'b1;
        if (rcfg.rx_irq_enable) begin
          object_irq_pending_next[match_idx_reg] = 1'b1;
        end
        transmit_request_next[match_idx_reg] = 1'b0;
      end else if (rcfg.remote_answer_enable) begin
        transmit_request_next[match_idx_reg] = 1'b1;
      end else if (rcfg.use_acceptance_mask) begin
        rcfg.object_identifier = hdr_reg.id;
        rcfg.xtd = hdr_reg.xtd;
        rcfg.dlc = hdr_reg.dlc;
        rcfg.fd_format = 1'b0;
        rcfg.bit_rate_switch = 1'b0;
        rcfg.error_state = 1'b0;
        mem_we = 1'b1;
        new_data_flag_next[match_idx_reg] = 1'b1;
        transmit_request_next[match_idx_reg] = 1'b0;
      end
      mem_wdata = rcfg;
    end
    if (do_tx_load) begin
      new_data_flag_next[tx_sel] = 1'b0;
    end
    if (bus.tx_ok && tx_busy_reg && cfg_mem[tx_idx_reg].tx_irq_enable) begin
      object_irq_pending_next[tx_idx_reg] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_reg <= '0;
      new_data_flag_reg <= '0;
      object_irq_pending_reg <= '0;
      transmit_request_reg <= '0;
    end else begin
      valid_reg <= valid_next;
      new_data_flag_reg <= new_data_flag_next;
      object_irq_pending_reg <= object_irq_pending_next;
      transmit_request_reg <= transmit_request_next;
    end
  end

  // The object store has no reset, so configuration survives a module reset.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      cfg_mem[mem_idx] <= mem_wdata;
    end
  end

  // ****************************************
  // Host buffer sets
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= '0;
      cmd_obj_reg <= '0;
      cmd_mask_reg <= '0;
      buf_reg <= '0;
    end else begin
      for (int s = 0; s < MHD_NUM_SETS; s++) begin
        if (bus.cmd_valid[s] && !busy_reg[s]) begin
          busy_reg[s] <= 1'b1;
          cmd_obj_reg[s] <= bus.cmd_obj[s];
          cmd_mask_reg[s] <= bus.cmd_mask[s];
        end
        if (bus.buf_wr[s] && !busy_reg[s]) begin
          buf_reg[s] <= bus.buf_wdata[s];
        end
      end
      if (state_reg == ST_READ) begin
        buf_reg[set_reg] <= mhd_merge(buf_reg[set_reg], cur_obj, cm);
      end
      if (state_reg == ST_RMW) begin
        buf_reg[set_reg] <= mhd_merge(cur_obj, buf_reg[set_reg], cm);
      end
      if (busy_clr) begin
        busy_reg[(state_reg == ST_IDLE) ? pick_set : set_reg] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Handler sequence and filtering
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      set_reg <= '0;
      scan_idx_reg <= '0;
      match_idx_reg <= '0;
      match_valid_reg <= 1'b0;
      rx_pend_reg <= 1'b0;
      store_pend_reg <= 1'b0;
      hdr_reg <= '0;
      rx_data_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (host_pend) begin
            set_reg <= pick_set;
            if (pick_ok) begin
              state_reg <= cmd_mask_reg[pick_set][MHD_CM_WR] ? ST_RMW : ST_READ;
            end
          end else if (do_store) begin
            store_pend_reg <= 1'b0;
            match_valid_reg <= 1'b0;
          end else if (rx_pend_reg) begin
            rx_pend_reg <= 1'b0;
            match_valid_reg <= 1'b0;
            scan_idx_reg <= '0;
            state_reg <= ST_SCAN;
          end
        end
        ST_READ: state_reg <= ST_IDLE;
        ST_RMW: state_reg <= ST_WRITE;
        ST_WRITE: state_reg <= ST_IDLE;
        ST_SCAN: begin
          if (mhd_match(cfg_mem[scan_idx_reg], valid_reg[scan_idx_reg],
                        new_data_flag_reg[scan_idx_reg], hdr_reg)) begin
            match_valid_reg <= 1'b1;
            match_idx_reg <= scan_idx_reg;
            state_reg <= ST_IDLE;
          end else if (scan_idx_reg == MHD_IDX_W'(MHD_NUM_OBJ - 1)) begin
            state_reg <= ST_IDLE;
          end else begin
            scan_idx_reg <= scan_idx_reg + 5'h01;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (bus.rx_hdr_valid) begin
        rx_pend_reg <= 1'b1;
        hdr_reg <= bus.rx_hdr;
      end
      if (bus.rx_end_ok) begin
        store_pend_reg <= 1'b1;
        rx_data_reg <= bus.rx_data;
      end
    end
  end

  // ****************************************
  // Transmission
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy_reg <= 1'b0;
      tx_nd_seen_reg <= 1'b0;
      tx_load_reg <= 1'b0;
      tx_idx_reg <= '0;
      tx_hdr_reg <= '0;
      tx_data_reg <= '0;
    end else begin
      tx_load_reg <= do_tx_load;
      if (do_tx_load) begin
        tx_busy_reg <= 1'b1;
        tx_nd_seen_reg <= 1'b0;
        tx_idx_reg <= tx_sel;
        tx_hdr_reg <= tx_hdr_next;
        tx_data_reg <= tcfg.data;
      end else if (tx_busy_reg) begin
        if (bus.tx_ok || bus.tx_fail) begin
          tx_busy_reg <= 1'b0;
        end
        if (new_data_flag_next[tx_idx_reg]) begin
          tx_nd_seen_reg <= 1'b1;
        end
      end
    end
  end

  assign bus.busy = busy_reg;
  assign bus.buf_rdata = buf_reg;
  assign bus.tx_load = tx_load_reg;
  assign bus.tx_hdr = tx_hdr_reg;
  assign bus.tx_data = tx_data_reg;
  assign valid_status = valid_reg;
  assign new_data_flag_status = new_data_flag_reg;
  assign object_irq_pending_status = object_irq_pending_reg;
  assign transmit_request_status = transmit_request_reg;
endmodule
`default_nettype wire

/* tb/mhd_monitor.sv */
// Checker of the buffer transfer and transmit load handshakes.
`timescale 1ns/1ps
`default_nettype none
module mhd_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [mhd_pkg::MHD_NUM_SETS-1:0] cmd_valid,
  input wire logic [mhd_pkg::MHD_NUM_SETS-1:0] busy,
  input wire logic core_ready,
  input wire logic tx_load,
  input wire mhd_pkg::mhd_hdr_t tx_hdr
);
  import mhd_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_take0; cmd_valid[0] && !busy[0] |=> busy[0]; endproperty
  a_take0: assert property (p_take0) else $error("set 0 not busy");
  property p_take1; cmd_valid[1] && !busy[1] |=> busy[1]; endproperty
  a_take1: assert property (p_take1) else $error("set 1 not busy");
  property p_free0; $rose(busy[0]) |-> ##[1:80] !busy[0]; endproperty
  a_free0: assert property (p_free0) else $error("set 0 stuck");
  property p_idle; tx_load |-> $past(busy) == 2'h0; endproperty
  a_idle: assert property (p_idle) else $error("load in transfer");
  property p_rdy; tx_load |-> $past(core_ready); endproperty
  a_rdy: assert property (p_rdy) else $error("load to busy core");
  property p_pulse; tx_load |=> !tx_load; endproperty
  a_pulse: assert property (p_pulse) else $error("load too long");
  property p_rmt; tx_load && tx_hdr.remote |-> !tx_hdr.fd_format && !tx_hdr.bit_rate_switch;
  endproperty
  a_rmt: assert property (p_rmt) else $error("remote not classic");
  property p_hold; !tx_load |-> $stable(tx_hdr); endproperty
  a_hold: assert property (p_hold) else $error("header moved");
endmodule
`default_nettype wire

/* tb/can_message_object_handler_tb.sv */
// Bench joining both ends of the message handler.
`timescale 1ns/1ps
`default_nettype none
module can_message_object_handler_tb;
  import mhd_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, rv = 1'b0, rs = 1'b0, crdy = 1'b0, tok = 1'b0;
  logic tfl = 1'b0, hv = 1'b0, eok = 1'b0, ti = 1'b0, done, tld;
  logic [5:0] ro = 6'h00;
  logic [7:0] rc = 8'h00;
  logic [31:0] nd, tq;
  mhd_obj_t rb = '0, res, o;
  mhd_hdr_t rh = '0, th;
  int n_fail = 0, checks = 0;
  mhd_if bus();
  always #25 clk = ~clk;
  mhd_host i_mhd_host(.clk(clk), .reset_n(reset_n), .bus(bus), .req_valid(rv), .req_set(rs),
    .req_obj(ro), .req_cmask(rc), .req_buf(rb), .req_tx_init(ti), .req_ready(), .done(done),
    .result(res), .core_ready_in(crdy), .tx_ok_in(tok), .tx_fail_in(tfl), .rx_hdr_valid_in(hv),
    .rx_hdr_in(rh), .rx_end_ok_in(eok), .rx_data_in(64'h1122334455667788), .tx_load_out(tld),
    .tx_hdr_out(th), .tx_data_out());
  mhd_device i_mhd_device(.clk(clk), .reset_n(reset_n), .bus(bus), .valid_status(),
    .new_data_flag_status(nd), .object_irq_pending_status(), .transmit_request_status(tq));
  mhd_monitor i_mhd_monitor(.clk(clk), .reset_n(reset_n), .cmd_valid(bus.cmd_valid),
    .busy(bus.busy), .core_ready(bus.core_ready), .tx_load(bus.tx_load), .tx_hdr(bus.tx_hdr));
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Waits for a transmit load when s is high, else for transfer completion.
  task automatic wt(input logic s);
    int k;
    for (k = 0; k < 99 && (s ? tld : done) !== 1'b1; k++) @(posedge clk);
    if (k > 98) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic xf(input logic s, input logic [5:0] ob, input logic [7:0] cm, input mhd_obj_t b);
    @(posedge clk);
    rv <= 1'b1;
    rs <= s;
    ro <= ob;
    rc <= cm;
    rb <= b;
    @(posedge clk);
    rv <= 1'b0;
    wt(1'b0);
  endtask
  task automatic fin(input logic ok);
    @(posedge clk);
    tok <= ok;
    tfl <= ~ok;
    @(posedge clk);
    tok <= 1'b0;
    tfl <= 1'b0;
  endtask
  task automatic frm(input logic [28:0] id, input logic rm);
    @(posedge clk);
    rh <= '{id, 1'b1, rm, 1'b0, 1'b0, 1'b0, 4'h8};
    hv <= 1'b1;
    @(posedge clk);
    hv <= 1'b0;
    repeat (40) @(posedge clk);
    eok <= 1'b1;
    @(posedge clk);
    eok <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  initial begin
    o = '0;
    o.flags.object_valid = 1'b1;
    o.cfg.dir = 1'b1;
    o.cfg.end_of_block = 1'b1;
    o.cfg.xtd = 1'b1;
    o.cfg.object_identifier = 29'h0aa;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    xf(1'b0, 6'h01, 8'hf7, o);
    o.cfg.object_identifier = 29'h0bb;
    o.cfg.remote_answer_enable = 1'b1;
    xf(1'b1, 6'h02, 8'hf7, o);
    cmp(tq[1:0], 2'h3);
    crdy <= 1'b1;
    wt(1'b1);
    cmp(th.id, 29'h0aa);
    fin(1'b0);
    wt(1'b1);
    cmp(th.id, 29'h0aa);
    fin(1'b1);
    wt(1'b1);
    cmp({th.id, tq[1:0]}, {29'h0bb, 2'h2});
    fin(1'b1);
    frm(29'h0aa, 1'b1);
    cmp(tq[1:0], 2'h0);
    frm(29'h0bb, 1'b1);
    cmp(tq[1:0], 2'h2);
    o.cfg.use_acceptance_mask = 1'b1;
    o.cfg.identifier_mask = '1;
    xf(1'b0, 6'h01, 8'hc0, o);
    frm(29'h0aa, 1'b1);
    cmp({nd[0], tq[0]}, 2'h2);
    o.cfg.dir = 1'b0;
    o.cfg.rx_irq_enable = 1'b1;
    o.cfg.object_identifier = 29'h0cc;
    xf(1'b0, 6'h03, 8'hf3, o);
    frm(29'h0cc, 1'b0);
    frm(29'h0cc, 1'b0);
    cmp(nd[2], 1'b1);
    xf(1'b0, 6'h03, 8'h7f, '0);
    cmp({res.cfg.message_lost, res.flags.object_irq_pending}, 2'h3);
    cmp(res.cfg.data, 64'h1122334455667788);
    xf(1'b0, 6'h03, 8'h82, '1);
    cmp(res.cfg.object_identifier, 29'h0cc);
    cmp(res.cfg.data, 64'h11223344ffffffff);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    xf(1'b0, 6'h03, 8'h22, '0);
    cmp({res.flags.object_valid, res.cfg.object_identifier}, {1'b0, 29'h0cc});
    cmp(res.cfg.data, 64'h00000000ffffffff);
    o.cfg.fd_format = 1'b1;
    o.cfg.bit_rate_switch = 1'b1;
    xf(1'b0, 6'h03, 8'hb7, o);
    wt(1'b1);
    cmp({th.remote, th.fd_format, th.bit_rate_switch}, 3'h4);
    o.cfg.xtd = 1'b0;
    o.cfg.object_identifier = 29'h1fffffff;
    ti <= 1'b1;
    xf(1'b0, 6'h04, 8'hf3, o);
    ti <= 1'b0;
    xf(1'b0, 6'h04, 8'h30, '0);
    cmp({res.flags, res.cfg.object_identifier}, {4'h8, 29'h1ffc0000});
    cmp({res.cfg.dir, res.cfg.rx_irq_enable}, 2'h2);
    end_of_test();
  end
endmodule
`default_nettype wire
